// ---- rtl/modbus_drive_regs.svh ----
// register offsets, codes and field positions of the drive command decoder
// assumes: included by bare name from the decoder and testbench files
`ifndef MODBUS_DRIVE_REGS_SVH
`define MODBUS_DRIVE_REGS_SVH

// --------------------------------------------------------------------------
// function and exception codes
// --------------------------------------------------------------------------
`define FC_READ_HOLDING   8'h03
`define FC_WRITE_SINGLE   8'h06
`define FC_WRITE_MULTI    8'h10
`define EXC_NONE          8'h00
`define EXC_ILLEGAL_FUNC  8'h01
`define EXC_ILLEGAL_ADDR  8'h02

// --------------------------------------------------------------------------
// holding register offsets and reset values
// --------------------------------------------------------------------------
`define REG_LOGIC_CMD     16'h2000
`define REG_FREQ_CMD      16'h2001
`define RESET_WORD        16'h0000
`define START_SRC_SERIAL  4'h3

// --------------------------------------------------------------------------
// logic command word field positions
// --------------------------------------------------------------------------
`define BIT_STOP          0
`define BIT_START         1
`define BIT_JOG           2
`define BIT_CLR_FAULT     3
`define FLD_DIR_HI        5
`define FLD_DIR_LO        4
`define BIT_KEYPAD        6
`define BIT_MOP_INC       7
`define FLD_ACC_HI        9
`define FLD_ACC_LO        8
`define FLD_DEC_HI        11
`define FLD_DEC_LO        10
`define FLD_SRC_HI        14
`define FLD_SRC_LO        12
`define BIT_MOP_DEC       15
`define BIT_LOGIC_IN1     6
`define BIT_LOGIC_IN2     7
`define FLD_STEP_HI       10
`define FLD_STEP_LO       8
`define BIT_FIND_HOME     11
`define BIT_HOLD_STEP     12
`define BIT_POS_REDEF     13
`define BIT_SYNC_EN       14
`define BIT_TRAV_DIS      15
`define RATE_SEL_1        2'b01
`define RATE_SEL_2        2'b10
`define SRC_NO_CMD        3'b000

`endif

// ---- rtl/modbus_drive_pkg.sv ----
// types shared by the drive command decoder
// assumes: nothing beyond the register header
package modbus_drive_pkg;

    // ----------------------------------------------------------------------
    // enumerations
    // ----------------------------------------------------------------------
    typedef enum logic [1:0] {
        DIR_NONE = 2'b00,
        DIR_FWD  = 2'b01,
        DIR_REV  = 2'b10
    } dir_t;

    typedef enum logic {
        PH_CAPTURE = 1'b0,
        PH_RUN     = 1'b1
    } phase_t;

    // ----------------------------------------------------------------------
    // command groups
    // ----------------------------------------------------------------------
    typedef struct packed {
        logic stop;
        logic start;
        logic jog;
        logic clear_faults;
    } basic_cmd_t;

    typedef struct packed {
        logic       force_keypad;
        logic       mop_inc;      // one-cycle pulse
        logic       mop_dec;      // one-cycle pulse
        logic       accel_rate2;  // 0 = rate 1, 1 = rate 2
        logic       decel_rate2;
        logic [2:0] freq_source;
    } vel_cmd_t;

    typedef struct packed {
        logic       logic_in1;
        logic       logic_in2;
        logic [2:0] step;
        logic       find_home;
        logic       hold_step;
        logic       pos_redefine;
        logic       sync_enable;
        logic       traverse_disable;
    } pos_cmd_t;

    typedef struct packed {
        phase_t     phase;
        logic       layout_pos;
        logic [15:0] cmd_word;
        logic [15:0] freq;
        logic       rsp_valid;
        logic [7:0] rsp_exc;
        logic [15:0] rsp_data;
        basic_cmd_t basic;
        dir_t       dir;
        vel_cmd_t   vel;
        pos_cmd_t   pos;
    } state_t;

endpackage : modbus_drive_pkg

// ---- rtl/modbus_drive_command_decoder.sv ----
// drive command decoder: applies decoded register requests to drive controls
// assumes: a frame parser hands over one register per request, already
// checked for node address and crc; multi-register writes come as a run of
// requests with the same function code
`timescale 1ns/1ps
`include "modbus_drive_regs.svh"

module modbus_drive_command_decoder
    import modbus_drive_pkg::*;
#(
    parameter bit POSITION_CAPABLE = 1'b1
) (
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        req_valid_i,
    input  wire logic [7:0]  req_func_i,
    input  wire logic [15:0] req_addr_i,
    input  wire logic [15:0] req_data_i,
    input  wire logic [3:0]  primary_start_source_i,
    input  wire logic        command_layout_select_i,
    output logic             rsp_valid_o,
    output logic [7:0]       rsp_exception_o,
    output logic [15:0]      rsp_data_o,
    output logic             layout_position_o,
    output basic_cmd_t       basic_cmd_o,
    output dir_t             direction_o,
    output vel_cmd_t         vel_cmd_o,
    output pos_cmd_t         pos_cmd_o,
    output logic [15:0]      freq_command_o
);

    // ----------------------------------------------------------------------
    // request classification
    // ----------------------------------------------------------------------
    state_t q;
    state_t d;
    logic   take;
    logic   is_read;
    logic   is_write;
    logic   func_ok;
    logic   addr_ok;
    logic   wr_logic;
    logic   serial_src;
    logic   cmd_ok;

    // the address is compared as received; a one-based master must offset it
    assign take       = req_valid_i && (q.phase == PH_RUN);
    assign is_read    = (req_func_i == `FC_READ_HOLDING);
    assign is_write   = (req_func_i == `FC_WRITE_SINGLE) || (req_func_i == `FC_WRITE_MULTI);
    assign func_ok    = is_read || is_write;
    assign addr_ok    = (req_addr_i == `REG_LOGIC_CMD) || (req_addr_i == `REG_FREQ_CMD);
    assign wr_logic   = take && is_write && (req_addr_i == `REG_LOGIC_CMD);
    assign serial_src = (primary_start_source_i == `START_SRC_SERIAL);
    assign cmd_ok     = wr_logic && serial_src;

    // ----------------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------------
    // mop steps are pulses so one write gives exactly one step
    always_comb begin
        d = q;
        d.rsp_valid   = 1'b0;
        d.vel.mop_inc = 1'b0;
        d.vel.mop_dec = 1'b0;
        case (q.phase)
            PH_CAPTURE: begin
                // layout taken once after reset; later changes wait
                d.layout_pos = command_layout_select_i & POSITION_CAPABLE;
                d.phase      = PH_RUN;
            end
            PH_RUN: begin
                if (req_valid_i) begin
                    d.rsp_valid = 1'b1;
                    d.rsp_exc   = `EXC_NONE;
                    d.rsp_data  = `RESET_WORD;
                    if (!func_ok) begin
                        d.rsp_exc = `EXC_ILLEGAL_FUNC;
                    end else if (!addr_ok) begin
                        d.rsp_exc = `EXC_ILLEGAL_ADDR;
                    end else if (is_read) begin
                        d.rsp_data = (req_addr_i == `REG_LOGIC_CMD) ? q.cmd_word : q.freq;
                    end else if (req_addr_i == `REG_FREQ_CMD) begin
                        d.freq = req_data_i;
                    end else if (serial_src) begin
                        // logic word from any other source is acked but dropped
                        d.cmd_word           = req_data_i;
                        d.basic.stop         = req_data_i[`BIT_STOP];
                        d.basic.start        = req_data_i[`BIT_START];
                        d.basic.jog          = req_data_i[`BIT_JOG];
                        d.basic.clear_faults = req_data_i[`BIT_CLR_FAULT];
                        case (req_data_i[`FLD_DIR_HI:`FLD_DIR_LO])
                            `RATE_SEL_1: d.dir = DIR_FWD;
                            `RATE_SEL_2: d.dir = DIR_REV;
                            default:     d.dir = q.dir;
                        endcase
                        if (!q.layout_pos) begin
                            d.vel.force_keypad = req_data_i[`BIT_KEYPAD];
                            d.vel.mop_inc      = req_data_i[`BIT_MOP_INC];
                            d.vel.mop_dec      = req_data_i[`BIT_MOP_DEC];
                            case (req_data_i[`FLD_ACC_HI:`FLD_ACC_LO])
                                `RATE_SEL_1: d.vel.accel_rate2 = 1'b0;
                                `RATE_SEL_2: d.vel.accel_rate2 = 1'b1;
                                default:     d.vel.accel_rate2 = q.vel.accel_rate2;
                            endcase
                            case (req_data_i[`FLD_DEC_HI:`FLD_DEC_LO])
                                `RATE_SEL_1: d.vel.decel_rate2 = 1'b0;
                                `RATE_SEL_2: d.vel.decel_rate2 = 1'b1;
                                default:     d.vel.decel_rate2 = q.vel.decel_rate2;
                            endcase
                            // a zero source code keeps the old pick
                            if (req_data_i[`FLD_SRC_HI:`FLD_SRC_LO] != `SRC_NO_CMD) begin
                                d.vel.freq_source = req_data_i[`FLD_SRC_HI:`FLD_SRC_LO];
                            end
                        end else begin
                            // step field is taken as a plain binary number
                            d.pos.logic_in1        = req_data_i[`BIT_LOGIC_IN1];
                            d.pos.logic_in2        = req_data_i[`BIT_LOGIC_IN2];
                            d.pos.step             = req_data_i[`FLD_STEP_HI:`FLD_STEP_LO];
                            d.pos.find_home        = req_data_i[`BIT_FIND_HOME];
                            d.pos.hold_step        = req_data_i[`BIT_HOLD_STEP];
                            d.pos.pos_redefine     = req_data_i[`BIT_POS_REDEF];
                            d.pos.sync_enable      = req_data_i[`BIT_SYNC_EN];
                            d.pos.traverse_disable = req_data_i[`BIT_TRAV_DIS];
                        end
                    end
                end
            end
            default: begin
                d.phase = PH_CAPTURE;
            end
        endcase
    end

    // ----------------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------------
    // async reset loads constants only; the layout strap is caught after release
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------------
    // outputs, all straight from the state register
    // ----------------------------------------------------------------------
    assign rsp_valid_o       = q.rsp_valid;
    assign rsp_exception_o   = q.rsp_exc;
    assign rsp_data_o        = q.rsp_data;
    assign layout_position_o = q.layout_pos;
    assign basic_cmd_o       = q.basic;
    assign direction_o       = q.dir;
    assign vel_cmd_o         = q.vel;
    assign pos_cmd_o         = q.pos;
    assign freq_command_o    = q.freq;

    // ----------------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    property p_bad_func;
        take && !func_ok |=> rsp_valid_o && (rsp_exception_o == `EXC_ILLEGAL_FUNC);
    endproperty
    a_bad_func: assert property (p_bad_func) else $error("bad function not refused");

    property p_apply_word;
        cmd_ok |=> (basic_cmd_o.start == $past(req_data_i[`BIT_START]))
                   && (basic_cmd_o.stop == $past(req_data_i[`BIT_STOP]));
    endproperty
    a_apply_word: assert property (p_apply_word) else $error("logic word not applied");

    property p_ignore_src;
        wr_logic && !serial_src |=> (basic_cmd_o == $past(basic_cmd_o)) && $stable(direction_o);
    endproperty
    a_ignore_src: assert property (p_ignore_src) else $error("wrong source obeyed");

    property p_variant;
        !POSITION_CAPABLE |-> !layout_position_o;
    endproperty
    a_variant: assert property (p_variant) else $error("reduced variant not velocity");

    property p_layout_hold;
        q.phase == PH_RUN |=> $stable(layout_position_o);
    endproperty
    a_layout_hold: assert property (p_layout_hold) else $error("layout moved mid-run");

    property p_dir_keep;
        cmd_ok && (req_data_i[`FLD_DIR_HI] == req_data_i[`FLD_DIR_LO]) |=> $stable(direction_o);
    endproperty
    a_dir_keep: assert property (p_dir_keep) else $error("direction moved on no cmd");

    property p_mop_pulse;
        cmd_ok && !layout_position_o && req_data_i[`BIT_MOP_INC]
            |=> vel_cmd_o.mop_inc ##1 (!vel_cmd_o.mop_inc || $past(cmd_ok));
    endproperty
    a_mop_pulse: assert property (p_mop_pulse) else $error("mop step not one pulse");

    property p_accel_sel;
        cmd_ok && !layout_position_o && (req_data_i[`FLD_ACC_HI:`FLD_ACC_LO] == `RATE_SEL_2)
            |=> vel_cmd_o.accel_rate2;
    endproperty
    a_accel_sel: assert property (p_accel_sel) else $error("accel rate 2 not selected");

    property p_src_keep;
        cmd_ok && (req_data_i[`FLD_SRC_HI:`FLD_SRC_LO] == `SRC_NO_CMD)
            |=> $stable(vel_cmd_o.freq_source);
    endproperty
    a_src_keep: assert property (p_src_keep) else $error("source moved on no command");

    property p_step;
        cmd_ok && layout_position_o
            |=> pos_cmd_o.step == $past(req_data_i[`FLD_STEP_HI:`FLD_STEP_LO]);
    endproperty
    a_step: assert property (p_step) else $error("position step wrong");

    property p_freq;
        take && is_write && (req_addr_i == `REG_FREQ_CMD) |=> freq_command_o == $past(req_data_i);
    endproperty
    a_freq: assert property (p_freq) else $error("frequency reference not taken");

    // ----------------------------------------------------------------------
    // answer path and the remaining command fields
    // ----------------------------------------------------------------------
    // every taken request gets one answer pulse, refused ones included
    property p_answer;
        take |=> rsp_valid_o;
    endproperty
    a_answer: assert property (p_answer) else $error("request not answered");

    property p_no_answer;
        !take |=> !rsp_valid_o;
    endproperty
    a_no_answer: assert property (p_no_answer) else $error("answer without request");

    property p_write_ok;
        take && is_write && addr_ok |=> (rsp_exception_o == `EXC_NONE);
    endproperty
    a_write_ok: assert property (p_write_ok) else $error("supported write refused");

    property p_bad_addr;
        take && func_ok && !addr_ok |=> (rsp_exception_o == `EXC_ILLEGAL_ADDR);
    endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("unknown register accepted");

    // a refused request must not move the frequency, basic, direction or position controls
    property p_refuse;
        take && !(func_ok && addr_ok)
            |=> $stable(freq_command_o) && $stable(basic_cmd_o)
                && $stable(direction_o) && $stable(pos_cmd_o);
    endproperty
    a_refuse: assert property (p_refuse) else $error("refusal changed state");

    property p_word_store;
        cmd_ok |=> (q.cmd_word == $past(req_data_i));
    endproperty
    a_word_store: assert property (p_word_store) else $error("command word not stored");

    property p_rd_word;
        take && is_read && (req_addr_i == `REG_LOGIC_CMD) |=> (rsp_data_o == $past(q.cmd_word));
    endproperty
    a_rd_word: assert property (p_rd_word) else $error("command readback wrong");

    property p_rd_freq;
        take && is_read && (req_addr_i == `REG_FREQ_CMD)
            |=> (rsp_data_o == $past(freq_command_o));
    endproperty
    a_rd_freq: assert property (p_rd_freq) else $error("frequency readback wrong");

    property p_jog_clr;
        cmd_ok |=> (basic_cmd_o.jog == $past(req_data_i[`BIT_JOG]))
                   && (basic_cmd_o.clear_faults == $past(req_data_i[`BIT_CLR_FAULT]));
    endproperty
    a_jog_clr: assert property (p_jog_clr) else $error("jog or clear not applied");

    property p_dir_set;
        cmd_ok && (req_data_i[`FLD_DIR_HI] != req_data_i[`FLD_DIR_LO])
            |=> (direction_o == $past(req_data_i[`FLD_DIR_HI:`FLD_DIR_LO]));
    endproperty
    a_dir_set: assert property (p_dir_set) else $error("direction not decoded");

    property p_keypad;
        cmd_ok && !layout_position_o
            |=> (vel_cmd_o.force_keypad == $past(req_data_i[`BIT_KEYPAD]));
    endproperty
    a_keypad: assert property (p_keypad) else $error("keypad force not applied");

    property p_mop_dec;
        cmd_ok && !layout_position_o
            |=> (vel_cmd_o.mop_dec == $past(req_data_i[`BIT_MOP_DEC]));
    endproperty
    a_mop_dec: assert property (p_mop_dec) else $error("mop decrement not applied");

    // mop pulses only ever follow an applied word, never a stale one
    property p_mop_idle;
        !cmd_ok |=> !vel_cmd_o.mop_inc && !vel_cmd_o.mop_dec;
    endproperty
    a_mop_idle: assert property (p_mop_idle) else $error("mop step without command");

    property p_decel_sel;
        cmd_ok && !layout_position_o && (req_data_i[`FLD_DEC_HI] != req_data_i[`FLD_DEC_LO])
            |=> (vel_cmd_o.decel_rate2 == $past(req_data_i[`FLD_DEC_HI]));
    endproperty
    a_decel_sel: assert property (p_decel_sel) else $error("decel rate not selected");

    property p_accel_keep;
        cmd_ok && (req_data_i[`FLD_ACC_HI] == req_data_i[`FLD_ACC_LO])
            |=> $stable(vel_cmd_o.accel_rate2);
    endproperty
    a_accel_keep: assert property (p_accel_keep) else $error("accel moved on no cmd");

    property p_src_load;
        cmd_ok && !layout_position_o && (req_data_i[`FLD_SRC_HI:`FLD_SRC_LO] != `SRC_NO_CMD)
            |=> (vel_cmd_o.freq_source == $past(req_data_i[`FLD_SRC_HI:`FLD_SRC_LO]));
    endproperty
    a_src_load: assert property (p_src_load) else $error("source not loaded");

    property p_pos_bits;
        cmd_ok && layout_position_o
            |=> (pos_cmd_o.logic_in1 == $past(req_data_i[`BIT_LOGIC_IN1]))
                && (pos_cmd_o.find_home == $past(req_data_i[`BIT_FIND_HOME]))
                && (pos_cmd_o.traverse_disable == $past(req_data_i[`BIT_TRAV_DIS]));
    endproperty
    a_pos_bits: assert property (p_pos_bits) else $error("position bits wrong");

    property p_pos_more;
        cmd_ok && layout_position_o
            |=> (pos_cmd_o.logic_in2 == $past(req_data_i[`BIT_LOGIC_IN2]))
                && (pos_cmd_o.hold_step == $past(req_data_i[`BIT_HOLD_STEP]))
                && (pos_cmd_o.pos_redefine == $past(req_data_i[`BIT_POS_REDEF]))
                && (pos_cmd_o.sync_enable == $past(req_data_i[`BIT_SYNC_EN]));
    endproperty
    a_pos_more: assert property (p_pos_more) else $error("position flags wrong");

    // the layout not in use keeps its outputs untouched
    property p_other_keep;
        cmd_ok |=> (layout_position_o && $stable(vel_cmd_o))
                   || (!layout_position_o && $stable(pos_cmd_o));
    endproperty
    a_other_keep: assert property (p_other_keep) else $error("idle layout changed");

endmodule : modbus_drive_command_decoder

// ---- verification/modbus_master_model.sv ----
// serial master model: issues one decoded register request per call
// assumes: a decoder that takes requests on the rising edge of sys_clk_i
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// request driver
// ----------------------------------------------------------------------
module modbus_master_model (
    input  wire logic  sys_clk_i,
    output logic       req_valid_o,
    output logic [7:0] req_func_o,
    output logic [15:0] req_addr_o,
    output logic [15:0] req_data_o
);

    // idle until the first request
    initial begin
        req_valid_o = 1'b0;
        req_func_o  = 8'h00;
        req_addr_o  = 16'h0000;
        req_data_o  = 16'h0000;
    end

    // one register per pulse; addresses are already 0-based
    // control word goes to 2000h and frequency to 2001h
    task automatic req(input logic [7:0] func, input logic [15:0] addr,
                       input logic [15:0] data);
        @(negedge sys_clk_i);
        req_valid_o = 1'b1;
        req_func_o  = func;
        req_addr_o  = addr;
        req_data_o  = data;
        @(negedge sys_clk_i);
        req_valid_o = 1'b0;
        // released lines must not keep showing the request
        req_func_o  = ~func;
        req_addr_o  = ~addr;
        req_data_o  = ~data;
    endtask : req

endmodule : modbus_master_model

// ---- verification/testbench.sv ----
// self-checking bench for the drive command decoder
// assumes: master model in its own file, design package and header on the path
`timescale 1ns/1ps
`include "modbus_drive_regs.svh"

module testbench;
    import modbus_drive_pkg::*;

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic        sys_clk;
    logic        resetn;
    logic        req_valid;
    logic [7:0]  req_func;
    logic [15:0] req_addr;
    logic [15:0] req_data;
    logic [3:0]  start_src;
    logic        layout_sel;
    logic        rsp_valid;
    logic [7:0]  rsp_exc;
    logic [15:0] rsp_data;
    logic        layout_pos;
    basic_cmd_t  basic;
    dir_t        dir;
    vel_cmd_t    vel;
    pos_cmd_t    pos;
    logic [15:0] freq;
    int          n_errors = 0;
    int          n_tests = 0;
    int          cycles = 0;
    logic [7:0]  fcs [7] = '{8'h03, 8'h06, 8'h10, 8'h01, 8'h04, 8'h05, 8'h2b};

    // ------------------------------------------------------------------
    // instances
    // ------------------------------------------------------------------
    modbus_drive_command_decoder dut_u (
        .sys_clk_i(sys_clk), .resetn_i(resetn), .req_valid_i(req_valid),
        .req_func_i(req_func), .req_addr_i(req_addr), .req_data_i(req_data),
        .primary_start_source_i(start_src), .command_layout_select_i(layout_sel),
        .rsp_valid_o(rsp_valid), .rsp_exception_o(rsp_exc), .rsp_data_o(rsp_data),
        .layout_position_o(layout_pos), .basic_cmd_o(basic), .direction_o(dir),
        .vel_cmd_o(vel), .pos_cmd_o(pos), .freq_command_o(freq)
    );

    modbus_master_model master_u (
        .sys_clk_i(sys_clk), .req_valid_o(req_valid), .req_func_o(req_func),
        .req_addr_o(req_addr), .req_data_o(req_data)
    );

    // clock and hang guard; about sixty cycles are expected
    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles >= 5000) begin
            n_errors++;
            final_report();
        end
    end

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    // request, then check the one-cycle answer at the next falling edge
    task automatic req(input logic [7:0] func, input logic [15:0] addr,
                       input logic [15:0] data, input logic [7:0] exc);
        master_u.req(func, addr, data);
        cmp(16'(rsp_valid), 16'h0001);
        cmp(16'(rsp_exc), 16'(exc));
    endtask : req

    // ten cycles of reset; returns after the capture edge has passed
    task automatic do_reset();
        resetn = 1'b0;
        repeat (10) @(negedge sys_clk);
        resetn = 1'b1;
        @(negedge sys_clk);
    endtask : do_reset

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask : end_test

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        sys_clk    = 1'b0;
        resetn     = 1'b0;
        start_src  = `START_SRC_SERIAL;
        layout_sel = 1'b0;
        do_reset();
        // only three codes accepted; refused ones leave the frequency alone
        foreach (fcs[i]) begin
            req(fcs[i], `REG_FREQ_CMD, 16'h1388,
                (i < 3) ? `EXC_NONE : `EXC_ILLEGAL_FUNC);
        end
        cmp(freq, 16'h1388);
        req(`FC_WRITE_SINGLE, 16'h2002, 16'h0001, `EXC_ILLEGAL_ADDR);
        cmp(freq, 16'h1388);
        end_test("function codes");
        // stop/start/jog/clear bits and direction decode
        req(`FC_WRITE_SINGLE, `REG_LOGIC_CMD, 16'h0016, `EXC_NONE);
        cmp(16'(basic), 16'h0006);
        cmp(16'(dir), 16'h0001);
        req(`FC_WRITE_SINGLE, `REG_LOGIC_CMD, 16'h0031, `EXC_NONE);
        cmp(16'(basic), 16'h0008);
        cmp(16'(dir), 16'h0001);
        end_test("basic word");
        // wrong start source drops the word but not the frequency
        start_src = 4'h1;
        req(`FC_WRITE_SINGLE, `REG_LOGIC_CMD, 16'h0002, `EXC_NONE);
        cmp(16'(basic), 16'h0008);
        req(`FC_WRITE_SINGLE, `REG_FREQ_CMD, 16'hea60, `EXC_NONE);
        cmp(freq, 16'hea60);
        req(`FC_READ_HOLDING, `REG_FREQ_CMD, 16'h0000, `EXC_NONE);
        cmp(rsp_data, 16'hea60);
        start_src = `START_SRC_SERIAL;
        end_test("start source");
        // velocity fields; layout select changes but waits for reset
        layout_sel = 1'b1;
        req(`FC_WRITE_SINGLE, `REG_LOGIC_CMD, 16'hd6e0, `EXC_NONE);
        cmp(16'(vel), 16'h00f5);
        cmp(16'(dir), 16'h0002);
        cmp(16'(layout_pos), 16'h0000);
        @(negedge sys_clk);
        cmp(16'(vel), 16'h0095);
        req(`FC_WRITE_SINGLE, `REG_LOGIC_CMD, 16'h0000, `EXC_NONE);
        cmp(16'(vel), 16'h0015);
        cmp(16'(dir), 16'h0002);
        end_test("velocity layout");
        // position layout after reset
        do_reset();
        cmp(16'(layout_pos), 16'h0001);
        req(`FC_WRITE_SINGLE, `REG_LOGIC_CMD, 16'hfdc0, `EXC_NONE);
        cmp(16'(pos), 16'h03bf);
        cmp(16'(vel), 16'h0000);
        req(`FC_WRITE_SINGLE, `REG_LOGIC_CMD, 16'h0040, `EXC_NONE);
        cmp(16'(pos), 16'h0200);
        req(`FC_READ_HOLDING, `REG_LOGIC_CMD, 16'h0000, `EXC_NONE);
        cmp(rsp_data, 16'h0040);
        end_test("position layout");
        final_report();
    end

endmodule : testbench
